// *** logic/eeprom_pkg.sv ***
package eeprom_pkg;

  // Array geometry
  localparam int ADDR_W    = 9;
  localparam int DEPTH     = 512;
  localparam int PAGE_SIZE = 16;
  localparam int PAGE_W    = 4;

  // Opcode layout: upper nibble zero, low three bits select the command
  localparam logic [3:0] OP_UPPER          = 4'h0;
  localparam logic [2:0] OP_READ           = 3'h3;
  localparam logic [2:0] OP_WRITE          = 3'h2;
  localparam logic [2:0] OP_SET_LATCH      = 3'h6;
  localparam logic [2:0] OP_CLEAR_LATCH    = 3'h4;
  localparam logic [2:0] OP_STATUS_READ    = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE   = 3'h1;
  localparam int         OP_TOP_ADDR_BIT   = 3;

  // Status byte field positions
  localparam int BUSY_BIT  = 0;
  localparam int LATCH_BIT = 1;
  localparam int BP_LO_BIT = 2;
  localparam int BP_HI_BIT = 3;

  // Reset values
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic [7:0] MEM_INIT = 8'hFF;

  // Internal write cycle time
  localparam int CLK_HZ       = 40_000_000;
  localparam int WRITE_MS     = 5;
  localparam int WRITE_CYCLES = (WRITE_MS * CLK_HZ) / 1000;

  typedef enum logic [2:0] {
    CMD_S  = 3'b000,
    ADDR_S = 3'b001,
    DATA_S = 3'b011,
    OUT_S  = 3'b010,
    IGN_S  = 3'b110
  } phase_e;

endpackage

// *** logic/link_if.sv ***
`timescale 1ns/1ps
interface link_if;
  logic sck_rise;
  logic sck_fall;
  logic sel;
  logic sel_rise;
  logic sel_fall;
  logic paused;
  logic mosi;
  modport front (output sck_rise, sck_fall, sel, sel_rise, sel_fall, paused, mosi);
  modport core  (input sck_rise, sck_fall, sel, sel_rise, sel_fall, paused, mosi);
endinterface

// *** logic/link_sync.sv ***
`timescale 1ns/1ps
module link_sync
(
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Raw pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic pause_n,
  // Conditioned link
  link_if.front     lnk
);

  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [1:0] prev_r;

  // Pin order: cs_n, sck, mosi, pause_n
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_r <= 4'h9;
      sync_r <= 4'h9;
      prev_r <= 2'h1;
    end
    else if (clk_en)
    begin
      meta_r <= {pause_n, mosi, sck, cs_n};
      sync_r <= meta_r;
      prev_r <= sync_r[1:0];
    end
  end

  // Edges are gated by select so idle clocking is ignored
  assign lnk.sel      = ~sync_r[0];
  assign lnk.sel_fall = prev_r[0] & ~sync_r[0];
  assign lnk.sel_rise = ~prev_r[0] & sync_r[0];
  assign lnk.sck_rise = ~prev_r[1] & sync_r[1] & ~sync_r[0] & clk_en;
  assign lnk.sck_fall = prev_r[1] & ~sync_r[1] & ~sync_r[0] & clk_en;
  assign lnk.mosi     = sync_r[2];
  assign lnk.paused   = ~sync_r[3];

endmodule

// *** logic/prog_timer.sv ***
`timescale 1ns/1ps
module prog_timer
#(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
)
(
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Start and status
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [22:0] cnt_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cnt_r <= 23'h0;
    else if (clk_en)
    begin
      if (start && cnt_r == 23'h0)
        cnt_r <= 23'(WRITE_CYCLES);
      else if (cnt_r != 23'h0)
        cnt_r <= cnt_r - 23'h1;
    end
  end

  assign busy = (cnt_r != 23'h0);
  assign done = clk_en & (cnt_r == 23'h1);

endmodule

// *** logic/spi_eeprom.sv ***
// Operation
// [RULE_01] Programming starts on select rise after valid write; ends within 5 ms.
// [RULE_02] An 8-bit instruction register loads from serial input on rising clocks.
// [RULE_03] Host keeps select low and pause released throughout each instruction.
// [RULE_04] All instruction, address and data bits move most significant first.
// [RULE_05] First input bit is captured on first rising clock after select falls.
// [RULE_06] Pause suspends the transfer; release resumes exactly where it stopped.
// [RULE_07] Read is opcode carrying address top bit, then low address byte.
// [RULE_08] Read shifts out addressed byte then increments pointer per byte.
// [RULE_09] Sequential read pointer wraps from 1FFh back to 000h.
// [RULE_10] Read ends when select rises; device stops driving output.
// [RULE_11] Write latch sets only on select rise after full set-latch byte.
// [RULE_12] Write without select rise after set-latch leaves array unchanged.
// [RULE_13] Write is opcode, low address, then one to 16 bytes in one page.
// [RULE_14] Page write past last location wraps to start of same page.
// [RULE_15] Program only if select rises right after a complete data byte.
// [RULE_16] During programming status reads work; array reads do not.
// [RULE_17] Host should poll the busy flag to learn when programming ends.
// [RULE_18] Completed programming clears the write latch.
// [RULE_19] Read opcode 0000 A 011; write opcode 0000 A 010.
// [RULE_20] Upper nibble 0000, bit 3 ignored; 110 set, 100 clear, 101, 001 status.
// [RULE_21] Status bit 0 is busy, bit 1 is the latch; both read-only.
// [RULE_22] Latch clears at reset, on clear, status write, array write, or protect low.
// [RULE_23] Select high keeps output off, ignores clock, resets bit counter.
// [RULE_24] Unknown opcodes are ignored until select rises; nothing changes.
`timescale 1ns/1ps
module spi_eeprom
#(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
)
(
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Serial link pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic pause_n,
  input  wire logic protect_n,
  output logic      miso_o,
  output logic      miso_oe,
  // Status view
  output logic      write_busy_flag,
  output logic      write_latch_flag,
  output logic      block_protect_low,
  output logic      block_protect_high
);

  link_if lnk ();

  link_sync u_sync
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .cs_n    (cs_n),
    .sck     (sck),
    .mosi    (mosi),
    .pause_n (pause_n),
    .lnk     (lnk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]                   mem [eeprom_pkg::DEPTH];
  logic [7:0]                   page_r [eeprom_pkg::PAGE_SIZE];
  logic [eeprom_pkg::PAGE_SIZE-1:0] page_vld_r;
  eeprom_pkg::phase_e           phase_r;
  logic [7:0]                   sh_r;
  logic [2:0]                   bit_r;
  logic [7:0]                   op_r;
  logic [eeprom_pkg::ADDR_W-1:0] addr_r;
  logic [7:0]                   tx_r;
  logic                         out_en_r;
  logic                         latch_r;
  logic                         armed_r;
  logic                         wr_pend_r;
  logic                         sr_pend_r;
  logic                         byte_done_r;
  logic [1:0]                   bp_r;
  logic [1:0]                   bp_new_r;
  logic                         wr_cycle_r;
  logic                         prot_meta_r;
  logic                         prot_r;
  logic                         miso_r;
  logic                         oe_r;
  logic                         busy_r;
  logic [eeprom_pkg::PAGE_SIZE-1:0] prog_vld_r;
  logic [eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W] prog_page_r;

  logic busy;
  logic done;
  logic start_prog;

  prog_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_timer
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .start   (start_prog),
    .busy    (busy),
    .done    (done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic is_op(input logic [7:0] op, input logic [2:0] low);
    is_op = (op[7:4] == eeprom_pkg::OP_UPPER) && (op[2:0] == low); // see [RULE_20]
  endfunction

  wire       rise_ok    = lnk.sck_rise & ~lnk.paused; // see [RULE_06]
  wire       fall_ok    = lnk.sck_fall & ~lnk.paused;
  wire [7:0] byte_in    = {sh_r[6:0], lnk.mosi}; // see [RULE_04]
  wire       byte_last  = rise_ok & (bit_r == 3'h7);
  wire       op_read    = is_op(byte_in, eeprom_pkg::OP_READ); // see [RULE_19]
  wire       op_write   = is_op(byte_in, eeprom_pkg::OP_WRITE);
  wire       op_sread   = is_op(byte_in, eeprom_pkg::OP_STATUS_READ);
  wire       op_swrite  = is_op(byte_in, eeprom_pkg::OP_STATUS_WRITE);
  wire       op_set     = is_op(byte_in, eeprom_pkg::OP_SET_LATCH);
  wire       op_clr     = is_op(byte_in, eeprom_pkg::OP_CLEAR_LATCH);
  wire       status_now = (op_r[2:0] == eeprom_pkg::OP_STATUS_READ);
  wire       swrite_now = (op_r[2:0] == eeprom_pkg::OP_STATUS_WRITE);
  // Select rise is only a valid end of write when it lands on a byte boundary
  wire       on_bound   = byte_done_r & (bit_r == 3'h0); // see [RULE_15]
  assign start_prog = lnk.sel_rise & ~busy & on_bound & (wr_pend_r | sr_pend_r)
                      & latch_r & prot_r; // see [RULE_01]
  wire [7:0] status_b   = {4'h0, bp_r, latch_r, busy}; // see [RULE_21]
  wire [eeprom_pkg::ADDR_W-1:0] addr_inc = addr_r + 9'h1; // see [RULE_09]
  wire [eeprom_pkg::PAGE_W-1:0] pg_idx   = addr_r[eeprom_pkg::PAGE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Serial front end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !lnk.sel)
    begin
      phase_r     <= eeprom_pkg::CMD_S;
      bit_r       <= 3'h0; // see [RULE_23]
      sh_r        <= 8'h0;
      out_en_r    <= 1'b0;
      byte_done_r <= 1'b0;
      if (reset)
        op_r <= 8'h0;
    end
    else if (clk_en && rise_ok)
    begin
      sh_r        <= byte_in; // see [RULE_02] [RULE_05]
      bit_r       <= bit_r + 3'h1;
      byte_done_r <= (bit_r == 3'h7);
      if (byte_last)
      begin
        case (phase_r)
          eeprom_pkg::CMD_S:
          begin
            op_r <= byte_in;
            if (op_read || op_write) // see [RULE_07] [RULE_13]
              phase_r <= eeprom_pkg::ADDR_S;
            else if (op_swrite)
              phase_r <= eeprom_pkg::DATA_S;
            else if (op_sread)
            begin
              phase_r  <= eeprom_pkg::OUT_S;
              out_en_r <= 1'b1;
            end
            else
              phase_r <= eeprom_pkg::IGN_S; // see [RULE_24]
          end
          eeprom_pkg::ADDR_S:
          begin
            if (op_r[2:0] == eeprom_pkg::OP_READ)
            begin
              // Array is unreadable while programming
              phase_r  <= busy ? eeprom_pkg::IGN_S : eeprom_pkg::OUT_S; // see [RULE_16]
              out_en_r <= ~busy;
            end
            else
              phase_r <= eeprom_pkg::DATA_S;
          end
          default:
            phase_r <= phase_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address, page buffer and output shifter

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      addr_r     <= 9'h0;
      tx_r       <= 8'h0;
      page_vld_r <= 16'h0;
      wr_pend_r  <= 1'b0;
      sr_pend_r  <= 1'b0;
      bp_new_r   <= eeprom_pkg::BP_RESET;
      armed_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (lnk.sel_fall)
      begin
        page_vld_r <= 16'h0;
        wr_pend_r  <= 1'b0;
        sr_pend_r  <= 1'b0;
        armed_r    <= 1'b0;
      end
      else if (byte_last)
      begin
        // Set-latch is only armed; it takes effect at select rise
        armed_r <= (phase_r == eeprom_pkg::CMD_S) & op_set; // see [RULE_11] [RULE_12]
        if (phase_r == eeprom_pkg::CMD_S)
        begin
          addr_r[8] <= byte_in[eeprom_pkg::OP_TOP_ADDR_BIT];
          tx_r      <= status_b;
        end
        else if (phase_r == eeprom_pkg::ADDR_S)
        begin
          addr_r[7:0] <= byte_in;
          tx_r        <= mem[{addr_r[8], byte_in}]; // see [RULE_08]
        end
        else if (phase_r == eeprom_pkg::DATA_S && !swrite_now)
        begin
          // The buffer being programmed must not change under the timer
          if (!busy)
          begin
            page_r[pg_idx]     <= byte_in;
            page_vld_r[pg_idx] <= 1'b1;
            wr_pend_r          <= 1'b1;
          end
          addr_r[eeprom_pkg::PAGE_W-1:0] <= pg_idx + 4'h1; // see [RULE_14]
        end
        else if (phase_r == eeprom_pkg::DATA_S)
        begin
          if (!busy)
          begin
            bp_new_r  <= byte_in[eeprom_pkg::BP_HI_BIT:eeprom_pkg::BP_LO_BIT];
            sr_pend_r <= 1'b1;
          end
        end
        else if (phase_r == eeprom_pkg::OUT_S && !status_now)
        begin
          addr_r <= addr_inc; // see [RULE_08] [RULE_09]
          tx_r   <= mem[addr_inc];
        end
        else if (phase_r == eeprom_pkg::OUT_S)
          tx_r <= status_b;
      end
      else if (phase_r == eeprom_pkg::OUT_S && fall_ok && bit_r != 3'h0)
        tx_r <= {tx_r[6:0], 1'b0}; // see [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array programming, latch and protection bits

  // One process owns the array; only slots filled by the write are programmed
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && done && wr_cycle_r)
    begin
      for (int i = 0; i < eeprom_pkg::PAGE_SIZE; i++)
      begin
        if (prog_vld_r[i])
          mem[{prog_page_r, 4'(i)}] <= page_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      latch_r     <= 1'b0; // see [RULE_22]
      bp_r        <= eeprom_pkg::BP_RESET;
      wr_cycle_r  <= 1'b0;
      prot_meta_r <= 1'b0;
      prot_r      <= 1'b0;
      busy_r      <= 1'b0;
      prog_vld_r  <= 16'h0;
      prog_page_r <= 5'h0;
    end
    else if (clk_en)
    begin
      prot_meta_r <= protect_n;
      prot_r      <= prot_meta_r;
      busy_r      <= busy;
      // Snapshot the page so later frames cannot disturb the write in flight
      if (start_prog)
      begin
        wr_cycle_r  <= wr_pend_r;
        prog_vld_r  <= page_vld_r;
        prog_page_r <= addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W];
      end
      if (done && !wr_cycle_r)
        bp_r <= bp_new_r;
      if (!prot_r || done) // see [RULE_18] [RULE_22]
        latch_r <= 1'b0;
      else if (lnk.sel_rise && on_bound && !busy && armed_r)
        latch_r <= 1'b1; // see [RULE_11]
      else if (lnk.sel_rise && on_bound && !busy && op_r[2:0] == eeprom_pkg::OP_CLEAR_LATCH
               && op_r[7:4] == eeprom_pkg::OP_UPPER)
        latch_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      miso_r <= 1'b0;
      oe_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      miso_r <= tx_r[7];
      oe_r   <= lnk.sel & out_en_r & ~lnk.paused; // see [RULE_10] [RULE_23]
    end
  end

  assign miso_o             = miso_r;
  assign miso_oe            = oe_r;
  assign write_busy_flag    = busy_r;
  assign write_latch_flag   = latch_r;
  assign block_protect_low  = bp_r[0];
  assign block_protect_high = bp_r[1];

endmodule

// *** tb/spi_eeprom_asserts.sv ***
`timescale 1ns/1ps
module spi_eeprom_asserts
#(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
)
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic reset,
  // Pins
  input wire logic cs_n,
  input wire logic protect_n,
  input wire logic miso_oe,
  // Status view
  input wire logic write_busy_flag,
  input wire logic write_latch_flag,
  input wire logic block_protect_low,
  input wire logic block_protect_high
);
  int busy_cnt_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Length of the running programming cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset || !write_busy_flag)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy_cnt_r + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet:
    assert property (disable iff (1'b0) reset |=> !write_latch_flag && !write_busy_flag)
      else $error("latch or busy set after reset");
  a_idle_quiet:
    assert property (cs_n [*6] |-> !miso_oe)
      else $error("output driven while deselected");
  a_busy_span:
    assert property ($fell(write_busy_flag) |->
      busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1)
      else $error("programming time off");
  a_busy_on_sel:
    assert property ($rose(write_busy_flag) |-> cs_n && $past(write_latch_flag))
      else $error("programming began without latch or select");
  a_latch_on_sel:
    assert property ($rose(write_latch_flag) |-> cs_n && protect_n)
      else $error("latch set in mid frame");
  a_latch_done:
    assert property ($fell(write_busy_flag) |-> ##[0:2] !write_latch_flag)
      else $error("latch kept after programming");
  a_protect_pin:
    assert property (!protect_n [*4] |-> !write_latch_flag)
      else $error("latch set while protect low");
  a_bp_on_done:
    assert property ($changed({block_protect_high, block_protect_low}) |->
      $past(write_busy_flag) || $past(write_busy_flag, 2))
      else $error("protect bits moved outside a status write");
endmodule

bind spi_eeprom spi_eeprom_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_spi_eeprom_asserts
(
  .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .protect_n(protect_n),
  .miso_oe(miso_oe), .write_busy_flag(write_busy_flag),
  .write_latch_flag(write_latch_flag), .block_protect_low(block_protect_low),
  .block_protect_high(block_protect_high)
);

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
(
  // Clock
  input  wire logic sys_clk,
  // Link
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  output logic      pause_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  int hold_at = -1;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    pause_n = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Clock stays low between frames; a released data line flips
  task automatic sel(input logic on);
    tk(4);
    cs_n = !on;
    if (!on)
      mosi = !mosi;
    tk(4);
  endtask

  // Mode 0 byte; read bit taken early in the high phase, before the
  // device reacts to the rising clock and loads its next byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      tk(4);
      if (i == hold_at)
      begin
        pause_n = 1'b0;
        tk(4);
        sck = 1'b1;
        tk(4);
        sck = 1'b0;
        tk(4);
        pause_n = 1'b1;
        tk(4);
      end
      sck = 1'b1;
      tk(2);
      rx[i] = miso_oe ? miso_o : 1'bx;
      tk(2);
      sck = 1'b0;
    end
  endtask
endmodule

// *** tb/spi_eeprom_tb.sv ***
`timescale 1ns/1ps
module spi_eeprom_tb;
  localparam int WC = 400;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       protect_n = 1'b1;
  logic       clk_en = 1'b1;
  logic       cs_n, sck, mosi, pause_n, miso_o, miso_oe;
  logic       busy_f, latch_f, bp_lo, bp_hi;
  logic [7:0] rxq [$];
  int         n_fail = 0;
  int         n_tests = 0;

  always #12.5 sys_clk = ~sys_clk;

  spi_eeprom #(.WRITE_CYCLES(WC)) u_spi_eeprom
  (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .cs_n(cs_n), .sck(sck),
    .mosi(mosi), .pause_n(pause_n), .protect_n(protect_n), .miso_o(miso_o),
    .miso_oe(miso_oe), .write_busy_flag(busy_f), .write_latch_flag(latch_f),
    .block_protect_low(bp_lo), .block_protect_high(bp_hi)
  );

  spi_host_model u_spi_host_model
  (
    .sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .pause_n(pause_n),
    .miso_o(miso_o), .miso_oe(miso_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] txq [$]);
    logic [7:0] r;
    rxq = {};
    u_spi_host_model.sel(1'b1);
    foreach (txq[i])
    begin
      u_spi_host_model.xfer(txq[i], r);
      rxq.push_back(r);
    end
    u_spi_host_model.sel(1'b0);
    tk(4);
  endtask

  // Polls the status byte over the link, as a host would, not the busy pin
  task automatic wait_done();
    int k;
    cmp("busy start", 8'h01, {7'h00, busy_f});
    frame({8'h05, 8'h00});
    for (k = 0; k < 20 && rxq[1][0] !== 1'b0; k++)
      frame({8'h05, 8'h00});
    cmp("busy end", 8'h00, {7'h00, busy_f});
    cmp("latch after", 8'h00, {7'h00, latch_f});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cmp("latch", 8'h00, {7'h00, latch_f});
    cmp("busy", 8'h00, {7'h00, busy_f});
    cmp("drive", 8'h00, {7'h00, miso_oe});
    $display("t_reset done");
  endtask

  task automatic t_latch();
    logic [7:0] op [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
    foreach (op[i])
    begin
      frame({op[i]});
      cmp("latch code", {7'h00, op[i][1]}, {7'h00, latch_f});
    end
    frame({8'h06});
    // A clear frame sent while frozen must leave no trace
    clk_en = 1'b0;
    frame({8'h04});
    clk_en = 1'b1;
    tk(4);
    cmp("latch frozen", 8'h01, {7'h00, latch_f});
    protect_n = 1'b0;
    tk(6);
    cmp("latch protect", 8'h00, {7'h00, latch_f});
    protect_n = 1'b1;
    $display("t_latch done");
  endtask

  task automatic t_write();
    frame({8'h06});
    frame({8'h0A, 8'h1E, 8'h11, 8'h22, 8'h33});
    frame({8'h05, 8'h00});
    cmp("status busy", 8'h03, rxq[1] & 8'h0F);
    wait_done();
    frame({8'h0B, 8'h1E, 8'h00, 8'h00});
    cmp("read 11E", 8'h11, rxq[2]);
    cmp("read 11F", 8'h22, rxq[3]);
    frame({8'h0B, 8'h10, 8'h00});
    cmp("page wrap", 8'h33, rxq[2]);
    $display("t_write done");
  endtask

  task automatic t_roll();
    frame({8'h06});
    frame({8'h0A, 8'hFF, 8'hA5});
    wait_done();
    frame({8'h06});
    frame({8'h02, 8'h00, 8'h3C});
    wait_done();
    u_spi_host_model.hold_at = 3;
    frame({8'h0B, 8'hFF, 8'h00, 8'h00});
    u_spi_host_model.hold_at = -1;
    cmp("read 1FF", 8'hA5, rxq[2]);
    cmp("rollover", 8'h3C, rxq[3]);
    cmp("drive off", 8'h00, {7'h00, miso_oe});
    $display("t_roll done");
  endtask

  task automatic t_abort();
    frame({8'h06});
    frame({8'h0A, 8'h1E});
    cmp("abort busy", 8'h00, {7'h00, busy_f});
    frame({8'h04});
    frame({8'h06, 8'h0A, 8'h1E, 8'h77});
    cmp("no latch busy", 8'h00, {7'h00, busy_f});
    frame({8'h06});
    frame({8'h8A, 8'h1E, 8'h77});
    frame({8'h07, 8'h1E, 8'h77});
    cmp("unknown busy", 8'h00, {7'h00, busy_f});
    cmp("unknown latch", 8'h01, {7'h00, latch_f});
    frame({8'h0B, 8'h1E, 8'h00});
    cmp("array kept", 8'h11, rxq[2]);
    $display("t_abort done");
  endtask

  task automatic t_status();
    frame({8'h06});
    frame({8'h01, 8'h0C});
    wait_done();
    cmp("protect bits", 8'h03, {6'h00, bp_hi, bp_lo});
    frame({8'h0D, 8'h00});
    cmp("status", 8'h0C, rxq[1] & 8'h0F);
    $display("t_status done");
  endtask

  task automatic end_of_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    tk(4);
    t_reset();
    t_latch();
    t_write();
    t_roll();
    t_abort();
    t_status();
    end_of_test();
  end

  // Whole run needs well under this span
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
